//--- core/ebac_mem.v
// Byte storage array with registered read data
`timescale 1ns/1ps
`include "ebac_regs.vh"

module ebac_mem (
	input wire clk,
	input wire rst,
	input wire wrEn,
	input wire [`EBAC_AW-1:0] wrAddr,
	input wire [7:0] wrData,
	input wire rdEn,
	input wire [`EBAC_AW-1:0] rdAddr,
	output reg [7:0] rdData_q
);
	reg [7:0] cells [0:`EBAC_DEPTH-1];

	always @(posedge clk) begin
		if (wrEn) begin
			cells[wrAddr] <= wrData;
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			rdData_q <= 8'h00;
		end else if (rdEn) begin
			rdData_q <= cells[rdAddr];
		end
	end
endmodule

//--- core/ebac_regs.vh
// Register map, field positions, reset values and timing counts of the storage controller
`ifndef EBAC_REGS_VH
`define EBAC_REGS_VH

// ----------------------------------------------------------------
// Register byte addresses on the bus
// ----------------------------------------------------------------
`define EBAC_ADDR_STORAGE_ADDRESS 4'h0
`define EBAC_ADDR_STORAGE_DATA 4'h4
`define EBAC_ADDR_STORAGE_CONTROL 4'h8

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define EBAC_BIT_READ_STROBE 0
`define EBAC_BIT_PROGRAM_STROBE 1
`define EBAC_BIT_PROGRAM_ARM 2
`define EBAC_BIT_READY_IRQ_ENABLE 3
`define EBAC_BIT_MODE_LO 4
`define EBAC_BIT_MODE_HI 5

// ----------------------------------------------------------------
// Mode encodings
// ----------------------------------------------------------------
`define EBAC_MODE_ATOMIC 2'h0
`define EBAC_MODE_ERASE 2'h1
`define EBAC_MODE_WRITE 2'h2
`define EBAC_MODE_RESERVED 2'h3

// ----------------------------------------------------------------
// Sizes and reset values
// ----------------------------------------------------------------
`define EBAC_DEPTH 64
`define EBAC_AW 6
`define EBAC_ERASED_BYTE 8'hff
`define EBAC_RST_ADDRESS 6'h00
`define EBAC_RST_DATA 8'h00
`define EBAC_RST_MODE 2'h0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define EBAC_READ_STALL 3'h4
`define EBAC_PROG_STALL 3'h2
`define EBAC_ARM_CYCLES 3'h4
`define EBAC_OSC_KHZ 1000
`define EBAC_T_ATOMIC_US 3400
`define EBAC_T_SPLIT_US 1800
`define EBAC_TICKS_ATOMIC ((`EBAC_T_ATOMIC_US * `EBAC_OSC_KHZ) / 1000)
`define EBAC_TICKS_SPLIT ((`EBAC_T_SPLIT_US * `EBAC_OSC_KHZ) / 1000)
`define EBAC_TICK_W 16

`endif

//--- core/ebac_top.v
// Byte storage access controller with AHB-Lite register slave
//
// Summary of operation
// RULE1: Sixty-four individually readable and writable bytes.
// RULE2: Address, data, control registers reachable by software.
// RULE3: Hardware times programming, exposes completion.
// RULE4: Read strobe stalls processor four cycles.
// RULE5: Program strobe stalls processor two cycles.
// RULE6: Mode zero, armed strobe: erase and write.
// RULE7: Mode one, armed strobe: erase only.
// RULE8: Mode two, armed strobe: write only.
// RULE9: Program strobe stays set until finished.
// RULE10: No other operation while programming; a read strobe written together with the program strobe still runs.
// RULE11: Software erases before write-only mode.
// RULE12: Durations timed from calibrated oscillator.
// RULE13: Software loads address and data first.
// RULE14: Software polls strobe clear before next.
// RULE15: Software keeps interrupts off during arming.
// RULE16: Atomic 3.4 ms, split 1.8 ms; mode three reserved.
// RULE17: Arm self-clears after four cycles; required.
// RULE18: Mode writes ignored while programming.
// RULE19: Ready interrupt level when both enables set.
// RULE20: Read strobe loads addressed byte into data.
// RULE21: Six-bit linear address, upper bits zero.
`timescale 1ns/1ps
`include "ebac_regs.vh"

module ebac_top (
	input wire clk,
	input wire rst,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata_q,
	output reg hreadyout_q,
	output reg hresp_q,
	input wire oscIn,
	input wire globalIrqEnable,
	output reg readyIrq_q,
	output reg cpuStall_q
);
	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	reg [`EBAC_AW-1:0] address_q;
	reg [7:0] data_q;
	reg [1:0] mode_q;
	reg readyIrqEnable_q;
	reg [2:0] armCnt_q;
	reg programStrobe_q;
	reg [1:0] opMode_q;
	reg [`EBAC_TICK_W-1:0] tickCnt_q;
	reg [2:0] stallCnt_q;
	reg rdReq_q;
	reg rdLoad_q;
	reg memWrEn_q;
	reg [7:0] memWrData_q;
	reg dataSel_q;
	reg dataWrite_q;
	reg [3:0] dataAddr_q;
	reg oscS1_q;
	reg oscS2_q;
	reg oscS3_q;
	reg oscLvl_q;

	wire [7:0] memRdData;
	wire armed = (armCnt_q != 3'h0);
	wire addrTaken = hsel & htrans[1] & hready;
	wire wrApply = dataSel_q & dataWrite_q & hready;
	wire ctlWrite = wrApply & (dataAddr_q == `EBAC_ADDR_STORAGE_CONTROL);
	wire [1:0] wrMode = hwdata[`EBAC_BIT_MODE_HI:`EBAC_BIT_MODE_LO];
	wire readStart = ctlWrite & hwdata[`EBAC_BIT_READ_STROBE] & ~programStrobe_q; // [RULE10]
	wire progStart = ctlWrite & hwdata[`EBAC_BIT_PROGRAM_STROBE] & armed
		& ~programStrobe_q & (mode_q != `EBAC_MODE_RESERVED); // [RULE17] [RULE16]
	wire [7:0] controlView = {2'h0, mode_q, readyIrqEnable_q, armed, programStrobe_q, 1'b0};
	// Tick counts are integers; keep only the counter width
	wire [31:0] ticksAtomicFull = `EBAC_TICKS_ATOMIC;
	wire [31:0] ticksSplitFull = `EBAC_TICKS_SPLIT;
	wire [`EBAC_TICK_W-1:0] ticksAtomic = ticksAtomicFull[`EBAC_TICK_W-1:0];
	wire [`EBAC_TICK_W-1:0] ticksSplit = ticksSplitFull[`EBAC_TICK_W-1:0];
	wire oscTick = (oscS2_q == oscS3_q) & oscS3_q & ~oscLvl_q;

	// ----------------------------------------------------------------
	// Bus address phase capture and read data
	// ----------------------------------------------------------------
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			dataSel_q <= 1'b0;
			dataWrite_q <= 1'b0;
			dataAddr_q <= 4'h0;
			hrdata_q <= 32'h00000000;
			hresp_q <= 1'b0;
		end else begin
			hresp_q <= 1'b0;
			if (hready) begin
				dataSel_q <= addrTaken;
				dataWrite_q <= hwrite;
				dataAddr_q <= {haddr[3:2], 2'h0};
			end
			if (addrTaken & ~hwrite) begin
				case ({haddr[3:2], 2'h0}) // [RULE2]
					`EBAC_ADDR_STORAGE_ADDRESS: begin
						hrdata_q <= {26'h0000000, address_q}; // [RULE21]
					end
					`EBAC_ADDR_STORAGE_DATA: begin
						hrdata_q <= {24'h000000, data_q};
					end
					`EBAC_ADDR_STORAGE_CONTROL: begin
						hrdata_q <= {24'h000000, controlView}; // [RULE3]
					end
					default: begin
						hrdata_q <= 32'h00000000;
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Processor stall through the bus ready
	// ----------------------------------------------------------------
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			stallCnt_q <= 3'h0;
			hreadyout_q <= 1'b1;
			cpuStall_q <= 1'b0;
		end else begin
			if (readStart) begin
				stallCnt_q <= `EBAC_READ_STALL; // [RULE4]
				hreadyout_q <= 1'b0;
				cpuStall_q <= 1'b1;
			end else if (progStart) begin
				stallCnt_q <= `EBAC_PROG_STALL; // [RULE5]
				hreadyout_q <= 1'b0;
				cpuStall_q <= 1'b1;
			end else begin
				if (stallCnt_q != 3'h0) begin
					stallCnt_q <= stallCnt_q - 3'h1;
				end
				hreadyout_q <= (stallCnt_q <= 3'h1);
				cpuStall_q <= (stallCnt_q > 3'h1);
			end
		end
	end

	// ----------------------------------------------------------------
	// Software registers
	// ----------------------------------------------------------------
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			address_q <= `EBAC_RST_ADDRESS;
			mode_q <= `EBAC_RST_MODE;
			readyIrqEnable_q <= 1'b0;
			armCnt_q <= 3'h0;
		end else begin
			if (wrApply & (dataAddr_q == `EBAC_ADDR_STORAGE_ADDRESS)) begin
				address_q <= hwdata[`EBAC_AW-1:0]; // [RULE21]
			end
			if (ctlWrite) begin
				readyIrqEnable_q <= hwdata[`EBAC_BIT_READY_IRQ_ENABLE];
				if (~programStrobe_q) begin
					mode_q <= wrMode; // [RULE18]
				end
			end
			if (ctlWrite & hwdata[`EBAC_BIT_PROGRAM_ARM]) begin
				armCnt_q <= `EBAC_ARM_CYCLES; // [RULE17]
			end else if (progStart) begin
				armCnt_q <= 3'h0;
			end else if (armed) begin
				armCnt_q <= armCnt_q - 3'h1; // [RULE17]
			end
		end
	end

	// ----------------------------------------------------------------
	// Data register and byte read path
	// ----------------------------------------------------------------
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			data_q <= `EBAC_RST_DATA;
			rdReq_q <= 1'b0;
			rdLoad_q <= 1'b0;
		end else begin
			rdReq_q <= readStart; // [RULE20]
			rdLoad_q <= rdReq_q;
			if (rdLoad_q) begin
				data_q <= memRdData; // [RULE20]
			end else if (wrApply & (dataAddr_q == `EBAC_ADDR_STORAGE_DATA)) begin
				data_q <= hwdata[7:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Calibrated oscillator sampling
	// ----------------------------------------------------------------
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			oscS1_q <= 1'b0;
			oscS2_q <= 1'b0;
			oscS3_q <= 1'b0;
			oscLvl_q <= 1'b0;
		end else begin
			oscS1_q <= oscIn;
			oscS2_q <= oscS1_q;
			oscS3_q <= oscS2_q;
			if (oscS2_q == oscS3_q) begin
				oscLvl_q <= oscS3_q;
			end
		end
	end

	// ----------------------------------------------------------------
	// Programming sequencer
	// ----------------------------------------------------------------
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			programStrobe_q <= 1'b0;
			opMode_q <= `EBAC_MODE_ATOMIC;
			tickCnt_q <= {`EBAC_TICK_W{1'b0}};
			memWrEn_q <= 1'b0;
			memWrData_q <= 8'h00;
		end else begin
			memWrEn_q <= 1'b0;
			if (progStart) begin
				programStrobe_q <= 1'b1; // [RULE9]
				opMode_q <= mode_q;
				if (mode_q == `EBAC_MODE_ATOMIC) begin
					tickCnt_q <= ticksAtomic; // [RULE16] [RULE6]
				end else begin
					tickCnt_q <= ticksSplit; // [RULE16]
				end
			end else if (programStrobe_q & oscTick) begin
				if (tickCnt_q <= {{(`EBAC_TICK_W-1){1'b0}}, 1'b1}) begin
					tickCnt_q <= {`EBAC_TICK_W{1'b0}};
					programStrobe_q <= 1'b0; // [RULE9] [RULE3]
					memWrEn_q <= 1'b1; // [RULE1]
					case (opMode_q)
						`EBAC_MODE_ERASE: begin
							memWrData_q <= `EBAC_ERASED_BYTE; // [RULE7]
						end
						`EBAC_MODE_WRITE: begin
							memWrData_q <= data_q; // [RULE8]
						end
						default: begin
							memWrData_q <= data_q; // [RULE6]
						end
					endcase
				end else begin
					tickCnt_q <= tickCnt_q - {{(`EBAC_TICK_W-1){1'b0}}, 1'b1}; // [RULE12]
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Ready interrupt level
	// ----------------------------------------------------------------
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			readyIrq_q <= 1'b0;
		end else begin
			readyIrq_q <= readyIrqEnable_q & globalIrqEnable
				& ~programStrobe_q & ~memWrEn_q; // [RULE19]
		end
	end

	// ----------------------------------------------------------------
	// Storage array
	// ----------------------------------------------------------------
	ebac_mem u_mem (
		.clk(clk),
		.rst(rst),
		.wrEn(memWrEn_q),
		.wrAddr(address_q),
		.wrData(memWrData_q),
		.rdEn(rdReq_q),
		.rdAddr(address_q),
		.rdData_q(memRdData)
	);
endmodule

//--- dv/ebac_cpu.sv
// Processor-side bus master model
`timescale 1ns/1ps
module ebac_cpu (
	input wire clk,
	input wire hready,
	input wire [31:0] hrdata,
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata,
	output logic irqEn
);
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		irqEn = 1'b1;
	end
	task automatic wt;
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (!hready && n < 99);
		if (!hready) tb.hang();
	endtask
	task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] r);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {28'h0, a};
		wt();
		htrans <= 2'h0;
		hwdata <= d;
		wt();
		r = hrdata;
		hwdata <= ~d;
	endtask
	// Arms and strikes with interrupts held off
	task automatic prog(input logic [5:0] a, input logic [7:0] d, input logic [1:0] m);
		logic [31:0] r;
		xfer(1'b1, 4'h8, {26'h0, m, 4'h8}, r);
		xfer(1'b1, 4'h0, {26'h0, a}, r);
		xfer(1'b1, 4'h4, {24'h0, d}, r);
		irqEn <= 1'b0;
		xfer(1'b1, 4'h8, {26'h0, m, 4'hc}, r);
		xfer(1'b1, 4'h8, {26'h0, m, 4'ha}, r);
		irqEn <= 1'b1;
	endtask
	task automatic poll;
		logic [31:0] r;
		int n;
		n = 0;
		do begin
			xfer(1'b0, 4'h8, 32'h0, r);
			n++;
		end while (r[1] && n < 30000);
		if (r[1]) tb.hang();
	endtask
endmodule

//--- dv/ebac_monitor.sv
// Port checker for the storage access controller
`timescale 1ns/1ps
module ebac_monitor (
	input wire clk,
	input wire rst,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [31:0] hwdata,
	input wire hready,
	input wire [31:0] hrdata_q,
	input wire hreadyout_q,
	input wire hresp_q,
	input wire globalIrqEnable,
	input wire readyIrq_q,
	input wire cpuStall_q
);
	logic ctlWr_q;
	logic rdV_q;
	logic [1:0] rdSel_q;
	wire taken = hsel && htrans[1] && hready;
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			ctlWr_q <= 1'b0;
			rdV_q <= 1'b0;
			rdSel_q <= 2'h0;
		end else if (hready) begin
			ctlWr_q <= taken && hwrite && haddr[3:2] == 2'h2;
			rdV_q <= taken && !hwrite;
			rdSel_q <= haddr[3:2];
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	a_resp_okay: assert property (hresp_q == 1'b0) else $error("bad response");
	a_stall_mirror: assert property (cpuStall_q == !hreadyout_q)
		else $error("stall mismatch");
	a_stall_cause: assert property ($fell(hreadyout_q) |-> $past(ctlWr_q && hready))
		else $error("stall without control write");
	a_stall_len: assert property ($fell(hreadyout_q) |->
		(!hreadyout_q[*2] ##1 hreadyout_q) or (!hreadyout_q[*4] ##1 hreadyout_q))
		else $error("stall length");
	a_read_stall: assert property (ctlWr_q && hready && hwdata[0] |=>
		hreadyout_q or (!hreadyout_q[*4] ##1 hreadyout_q)) else $error("read stall");
	a_irq_gate: assert property (readyIrq_q |-> $past(globalIrqEnable))
		else $error("irq without global enable");
	a_upper_zero: assert property (rdV_q && hready && rdSel_q != 2'h1 |->
		hrdata_q[31:6] == 26'h0) else $error("upper bits set");
	a_unmapped_zero: assert property (rdV_q && hready && rdSel_q == 2'h3 |->
		hrdata_q == 32'h0) else $error("unmapped read");
endmodule
bind ebac_top ebac_monitor u_mon (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hwdata,
	.hready, .hrdata_q, .hreadyout_q, .hresp_q, .globalIrqEnable, .readyIrq_q, .cpuStall_q);

//--- dv/tb.sv
// Self-checking bench for the storage controller
`timescale 1ns/1ps
`include "ebac_regs.vh"
module tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic osc = 1'b0;
	logic hsel, hwrite, hreadyout, hresp, irqEn, readyIrq, stall;
	logic [31:0] haddr, hwdata, hrdata, r;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [5:0] a;
	logic [7:0] d;
	int bad_count = 0;
	int num_checks = 0;
	int seed = 32252;
	int n;
	int lo;
	time t0;
	always #5 clk = ~clk;
	always #40 osc = ~osc;
	ebac_top u_dut (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hrdata_q(hrdata), .hreadyout_q(hreadyout), .hresp_q(hresp),
		.oscIn(osc), .globalIrqEnable(irqEn), .readyIrq_q(readyIrq), .cpuStall_q(stall));
	ebac_cpu u_cpu (.clk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .irqEn);
	function automatic int ticks(input int m);
		return m == 0 ? `EBAC_TICKS_ATOMIC : `EBAC_TICKS_SPLIT;
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic hang;
		bad_count++;
		print_verdict();
	endtask
	initial begin
		#900us;
		hang();
	end
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		u_cpu.xfer(1'b1, 4'hc, 32'hffffffff, r);
		for (int i = 0; i < 4; i++) begin
			u_cpu.xfer(1'b0, 4'(4 * i), 32'h0, r);
			chk("reset value", 32'h0, r);
		end
		u_cpu.xfer(1'b1, 4'h0, 32'hffffffff, r);
		u_cpu.xfer(1'b0, 4'h0, 32'h0, r);
		chk("address width", 32'h3f, r);
		a = 6'($random(seed));
		for (int m = 0; m < 3; m++) begin
			d = 8'($random(seed));
			u_cpu.prog(a, d, 2'(m)); // erase precedes write-only
			t0 = $time;
			u_cpu.xfer(1'b0, 4'h8, 32'h0, r);
			chk("busy strobe", 32'h1, {31'h0, r[1]});
			chk("irq while busy", 32'h0, {31'h0, readyIrq});
			u_cpu.xfer(1'b1, 4'h8, 32'h39, r);
			u_cpu.xfer(0, 4'h8, 32'h0, r);
			chk("mode kept", m, {30'h0, r[5:4]});
			u_cpu.xfer(1'b0, 4'h4, 32'h0, r);
			chk("read refused", {24'h0, d}, r);
			u_cpu.poll();
			n = int'(($time - t0) / 10);
			lo = ticks(m) * 8 - 10;
			chk("program time", 32'h1, {31'h0, n >= lo && n <= lo + 50});
			u_cpu.xfer(1'b1, 4'h4, 32'h0, r);
			u_cpu.xfer(1'b1, 4'h8, 32'h09, r);
			u_cpu.xfer(1'b0, 4'h4, 32'h0, r);
			chk("stored byte", m == 1 ? 32'hff : {24'h0, d}, r);
			chk("irq when ready", 32'h1, {31'h0, readyIrq});
		end
		u_cpu.xfer(1'b1, 4'h8, 32'h02, r);
		u_cpu.xfer(1'b0, 4'h8, 32'h0, r);
		chk("unarmed strobe", 32'h0, {31'h0, r[1]});
		u_cpu.xfer(1'b1, 4'h8, 32'h04, r);
		u_cpu.xfer(1'b0, 4'h8, 32'h0, r);
		chk("arm live", 32'h1, {31'h0, r[2]});
		repeat (5) @(posedge clk);
		u_cpu.xfer(1'b1, 4'h8, 32'h02, r);
		u_cpu.xfer(1'b0, 4'h8, 32'h0, r);
		chk("arm expired", 32'h0, {30'h0, r[2:1]});
		u_cpu.prog(a, d, 2'h3);
		u_cpu.xfer(1'b0, 4'h8, 32'h0, r);
		chk("reserved mode", 32'h0, {31'h0, r[1]});
		print_verdict();
	end
endmodule
